// ==== hw/mcx_pkg.sv ====
// Package for the two-axis motion control block.
// Assumes one 25 MHz clock and a 32-bit register port with byte offsets.
package mcx_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_AXIS_TYPE_SELECT = 8'h04;
  localparam logic [7:0] A_FEMAX = 8'h08;
  localparam logic [7:0] A_LIMSEL = 8'h0C;
  localparam logic [7:0] A_DEM0 = 8'h10;
  localparam logic [7:0] A_GAIN = 8'h14;
  localparam logic [7:0] A_SPEED = 8'h18;
  localparam logic [7:0] A_TORQ = 8'h1C;
  localparam logic [7:0] A_DEM1 = 8'h20;
  localparam logic [7:0] A_STATE = 8'h24;
  localparam logic [7:0] A_IRQ_ST = 8'h28;
  localparam logic [7:0] A_IRQ_MSK = 8'h2C;
  localparam logic [7:0] A_POS0 = 8'h30;
  localparam logic [7:0] A_POS1 = 8'h34;
  localparam logic [7:0] A_FERR0 = 8'h38;
  // Control bits
  localparam int CTL_EN = 0;
  localparam int CTL_PERIOD = 1;
  localparam int CTL_TORQUE = 2;
  localparam int CTL_OPEN = 3;
  localparam int CTL_CLR = 4;
  // Axis state word bits
  localparam int ST_FWD = 0;
  localparam int ST_REV = 1;
  localparam int ST_MERR = 2;
  localparam int ST_HALT = 3;
  // Interrupt bits
  localparam int IRQ_W = 6;
  localparam int IQ_MERR = 0;
  localparam int IQ_COMM = 1;
  localparam int IQ_FWD = 2;
  localparam int IQ_REV = 3;
  localparam int IQ_ENC = 4;
  localparam int IQ_TICK = 5;
  // Axis type codes
  localparam logic [7:0] AT_VIRTUAL = 8'h00;
  localparam logic [7:0] AT_SERVO1 = 8'h02;
  localparam logic [7:0] AT_ENC_IN = 8'h03;
  localparam logic [7:0] AT_SERVO0 = 8'h0D;
  localparam logic [7:0] AT_ENC_OUT = 8'h0E;
  // Limit selector codes and resets
  localparam logic [7:0] LIM_DRV_FWD = 8'h12;
  localparam logic [7:0] LIM_DRV_REV = 8'h13;
  localparam logic [31:0] FEMAX_RST = 32'h0000_1000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SERVO_SHORT_US = 500;
  localparam int SERVO_LONG_US = 1000;
  localparam int SERVO_SHORT_CYC = SERVO_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int SERVO_LONG_CYC = SERVO_LONG_US * (CLK_HZ / 1_000_000);
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int ENC_OUT_KPPS = 500;
  localparam int ENC_EDGE_NS = 1_000_000 / (ENC_OUT_KPPS * 4);
  localparam int ENC_STEP_CYC = (ENC_EDGE_NS + CLK_NS - 1) / CLK_NS;
  // Encoder output scaling: 64 counts per pulse, 4 edges per pulse
  localparam int ENC_COUNTS_PER_PULSE = 64;
  localparam int ENC_EDGE_SHIFT = $clog2(ENC_COUNTS_PER_PULSE / 4);
  localparam int ENC_Z_BITS = $clog2(4096);
endpackage

// ==== hw/mcx_top.sv ====
// Two-axis motion control core: servo axis 0 and configurable axis 1,
// following error check, limits and driver link watchdog.
// Assumes the driver link and register port run on i_clk; pins are async.
// Functional notes
// - Axis type selectors fix each axis function; axis 1 codes 0, 2, 3, 14.
// - Following error equals demanded position minus measured position.
// - Error above maximum raises motion error, disables driver, stops motion.
// - Driver link failure is detected and halts the whole system.
// - Limit selectors pick forward and reverse inputs; 18 and 19 mean driver.
// - Driver limit trip brakes at the driver and sets the state word bit.
// - Closed-loop speed reference comes from following error times gain.
// - Open-loop speed mode sends the fixed programmed speed reference.
// - Torque mode sends programmed torque; mode may change while running.
// - Axis 1 as servo runs a second control loop.
// - Axis 1 encoder input counts every edge of both phases, x4.
// - Axis 1 encoder output follows the axis internal position.
// - One output pulse per 64 internal position counts.
// - Z marker once per 4096 generated encoder edges.
// - Encoder output axis takes all servo axis commands and parameters; here it uses only the DEM1 position demand.
// - Virtual axis measured position always equals demanded position.
// - Servo cycle selectable as 500 us or 1000 us.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module mcx_top #(
  parameter int SHORT_CYC = mcx_pkg::SERVO_SHORT_CYC,
  parameter int LONG_CYC = mcx_pkg::SERVO_LONG_CYC,
  parameter int GEN_W = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_drv_strobe,
  input wire logic i_drv_ack,
  input wire logic [31:0] i_drv_pos0,
  input wire logic [31:0] i_drv_pos1,
  output logic o_drv_enable,
  output logic o_drv_torque,
  output logic [31:0] o_drv_ref,
  output logic [31:0] o_drv_ref1,
  input wire logic i_drv_fwd_lim,
  input wire logic i_drv_rev_lim,
  input wire logic [GEN_W-1:0] i_gen_in,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  output logic o_enc_a,
  output logic o_enc_b,
  output logic o_enc_z,
  output logic o_halted
);
  localparam int SW = GEN_W + 4;
  logic [31:0] ctrl_reg, femax_reg, dem0_reg, gain_reg, speed_reg, torq_reg, dem1_reg;
  logic [7:0] atype1_reg, fwd_sel_reg, rev_sel_reg;
  logic [31:0] pos0_reg, pos1_reg, cnt_reg;
  localparam int IRQ_W_L = mcx_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_st_reg, irq_msk_reg;
  logic [SW-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic merr_reg, halt_reg, wait_reg, fwd_reg, rev_reg;
  logic [1:0] enc_prev_reg;
  logic [31:0] edges_reg;
  logic [7:0] step_reg;
  logic tick, run, clr, fwd_now, rev_now, enc_up, enc_dn, enc_bad, fe_over;
  logic [31:0] fe0, fe1, abs0, abs1, target;
  logic [1:0] enc_idx, enc_d;
  logic [IRQ_W_L-1:0] ev;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change taken once stages two and three agree
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end
    else
    begin
      s1_reg <= {i_gen_in, i_drv_rev_lim, i_drv_fwd_lim, i_enc_b, i_enc_a};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  assign clr = i_wr && i_addr == mcx_pkg::A_CTRL && i_wdata[mcx_pkg::CTL_CLR];
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_reg <= mcx_pkg::CTRL_RST;
      femax_reg <= mcx_pkg::FEMAX_RST;
      atype1_reg <= mcx_pkg::AT_ENC_IN;
      fwd_sel_reg <= mcx_pkg::LIM_DRV_FWD;
      rev_sel_reg <= mcx_pkg::LIM_DRV_REV;
      dem0_reg <= '0;
      gain_reg <= '0;
      speed_reg <= '0;
      torq_reg <= '0;
      dem1_reg <= '0;
      irq_msk_reg <= '0;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        mcx_pkg::A_CTRL: ctrl_reg <= {28'h000_0000, i_wdata[3:0]};
        mcx_pkg::A_FEMAX: femax_reg <= i_wdata;
        mcx_pkg::A_AXIS_TYPE_SELECT:
        begin
          if (i_wdata[15:8] == mcx_pkg::AT_VIRTUAL || i_wdata[15:8] == mcx_pkg::AT_SERVO1 ||
              i_wdata[15:8] == mcx_pkg::AT_ENC_IN || i_wdata[15:8] == mcx_pkg::AT_ENC_OUT)
            atype1_reg <= i_wdata[15:8];
        end
        mcx_pkg::A_LIMSEL:
        begin
          fwd_sel_reg <= i_wdata[7:0];
          rev_sel_reg <= i_wdata[15:8];
        end
        mcx_pkg::A_DEM0: dem0_reg <= i_wdata;
        mcx_pkg::A_GAIN: gain_reg <= i_wdata;
        mcx_pkg::A_SPEED: speed_reg <= i_wdata;
        mcx_pkg::A_TORQ: torq_reg <= i_wdata;
        mcx_pkg::A_DEM1: dem1_reg <= i_wdata;
        mcx_pkg::A_IRQ_MSK: irq_msk_reg <= i_wdata[IRQ_W_L-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Servo cycle tick, 500 or 1000 us
  assign tick = ctrl_reg[mcx_pkg::CTL_PERIOD] ? (cnt_reg >= 32'(LONG_CYC - 1))
                                               : (cnt_reg >= 32'(SHORT_CYC - 1));
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cnt_reg <= '0;
    else
      cnt_reg <= tick ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Following errors
  assign fe0 = dem0_reg - pos0_reg;
  assign fe1 = dem1_reg - pos1_reg;
  assign abs0 = fe0[31] ? -fe0 : fe0;
  assign abs1 = fe1[31] ? -fe1 : fe1;
  assign fe_over = abs0 > femax_reg || (atype1_reg == mcx_pkg::AT_SERVO1 && abs1 > femax_reg);
  assign run = ctrl_reg[mcx_pkg::CTL_EN] && !merr_reg && !halt_reg;

  // Link watchdog and latched faults, set wins over clear
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      merr_reg <= 1'b0;
      halt_reg <= 1'b0;
      wait_reg <= 1'b0;
      o_drv_strobe <= 1'b0;
      pos0_reg <= '0;
    end
    else
    begin
      o_drv_strobe <= tick && run;
      if (o_drv_strobe)
        wait_reg <= 1'b1;
      else if (i_drv_ack)
        wait_reg <= 1'b0;
      if (i_drv_ack)
        pos0_reg <= i_drv_pos0;
      if (tick && run && fe_over)
        merr_reg <= 1'b1;
      else if (clr)
        merr_reg <= 1'b0;
      if (tick && wait_reg)
        halt_reg <= 1'b1;
      else if (clr)
        halt_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Driver references, updated each servo tick
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_drv_ref <= '0;
      o_drv_ref1 <= '0;
      o_drv_enable <= 1'b0;
      o_drv_torque <= 1'b0;
    end
    else if (!run || (tick && fe_over))
    begin
      o_drv_ref <= '0;
      o_drv_ref1 <= '0;
      o_drv_enable <= 1'b0;
    end
    else if (tick)
    begin
      o_drv_enable <= 1'b1;
      // Torque mode switchable at run time
      o_drv_torque <= ctrl_reg[mcx_pkg::CTL_TORQUE];
      if (ctrl_reg[mcx_pkg::CTL_TORQUE])
        o_drv_ref <= torq_reg;
      else if (ctrl_reg[mcx_pkg::CTL_OPEN])
        o_drv_ref <= speed_reg;
      else
        o_drv_ref <= 32'($signed(fe0) * $signed(gain_reg));
      o_drv_ref1 <= (atype1_reg == mcx_pkg::AT_SERVO1) ?
                    32'($signed(fe1) * $signed(gain_reg)) : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Limit source selection
  function automatic logic lim_pick(input logic [7:0] sel, input logic [SW-1:0] f);
    if (sel == mcx_pkg::LIM_DRV_FWD)
      return f[2];
    if (sel == mcx_pkg::LIM_DRV_REV)
      return f[3];
    if (sel < 8'(GEN_W))
      return f[4 + sel[$clog2(GEN_W)-1:0]];
    return 1'b0;
  endfunction
  assign fwd_now = lim_pick(fwd_sel_reg, filt_reg);
  assign rev_now = lim_pick(rev_sel_reg, filt_reg);
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
    end
    else
    begin
      fwd_reg <= fwd_now;
      rev_reg <= rev_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Quadrature decode, index order 00,10,11,01 when A leads
  assign enc_idx = {filt_reg[1], filt_reg[1] ^ filt_reg[0]};
  assign enc_d = enc_idx - {enc_prev_reg[1], enc_prev_reg[1] ^ enc_prev_reg[0]};
  assign enc_up = atype1_reg == mcx_pkg::AT_ENC_IN && enc_d == 2'd1;
  assign enc_dn = atype1_reg == mcx_pkg::AT_ENC_IN && enc_d == 2'd3;
  assign enc_bad = atype1_reg == mcx_pkg::AT_ENC_IN && enc_d == 2'd2;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      enc_prev_reg <= 2'b00;
      pos1_reg <= '0;
    end
    else
    begin
      enc_prev_reg <= filt_reg[1:0];
      unique case (atype1_reg)
        mcx_pkg::AT_ENC_IN:
        begin
          if (enc_up)
            pos1_reg <= pos1_reg + 32'h0000_0001;
          else if (enc_dn)
            pos1_reg <= pos1_reg - 32'h0000_0001;
        end
        mcx_pkg::AT_SERVO1:
        begin
          if (i_drv_ack)
            pos1_reg <= i_drv_pos1;
        end
        // Ideal axis; output axis takes the demand like a servo
        default: pos1_reg <= dem1_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Encoder output follows axis 1 position, rate limited
  assign target = 32'($signed(pos1_reg) >>> mcx_pkg::ENC_EDGE_SHIFT);
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      edges_reg <= '0;
      step_reg <= '0;
    end
    else if (atype1_reg != mcx_pkg::AT_ENC_OUT)
    begin
      edges_reg <= target;
      step_reg <= '0;
    end
    else if (step_reg != 8'h00)
      step_reg <= step_reg - 8'h01;
    else if (edges_reg != target)
    begin
      step_reg <= 8'(mcx_pkg::ENC_STEP_CYC - 1);
      edges_reg <= ($signed(target) > $signed(edges_reg)) ? edges_reg + 32'h0000_0001
                                                          : edges_reg - 32'h0000_0001;
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_enc_a <= 1'b0;
      o_enc_b <= 1'b0;
      o_enc_z <= 1'b0;
    end
    else
    begin
      o_enc_a <= edges_reg[1] ^ edges_reg[0];
      o_enc_b <= edges_reg[1];
      o_enc_z <= atype1_reg == mcx_pkg::AT_ENC_OUT &&
                 edges_reg[mcx_pkg::ENC_Z_BITS-1:0] == '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts and read port
  assign ev = {tick, enc_bad, rev_now && !rev_reg, fwd_now && !fwd_reg,
               tick && wait_reg, tick && run && fe_over};
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      irq_st_reg <= '0;
    else if (i_rd && i_addr == mcx_pkg::A_IRQ_ST)
      irq_st_reg <= ev;
    else
      irq_st_reg <= irq_st_reg | ev;
  end
  assign o_irq = |(irq_st_reg & irq_msk_reg);
  assign o_halted = halt_reg || merr_reg;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rdata <= '0;
    else if (!i_rd)
      o_rdata <= '0;
    else
    begin
      unique case (i_addr)
        mcx_pkg::A_CTRL: o_rdata <= ctrl_reg;
        mcx_pkg::A_AXIS_TYPE_SELECT: o_rdata <= {16'h0000, atype1_reg, mcx_pkg::AT_SERVO0};
        mcx_pkg::A_FEMAX: o_rdata <= femax_reg;
        mcx_pkg::A_LIMSEL: o_rdata <= {16'h0000, rev_sel_reg, fwd_sel_reg};
        mcx_pkg::A_DEM0: o_rdata <= dem0_reg;
        mcx_pkg::A_GAIN: o_rdata <= gain_reg;
        mcx_pkg::A_SPEED: o_rdata <= speed_reg;
        mcx_pkg::A_TORQ: o_rdata <= torq_reg;
        mcx_pkg::A_DEM1: o_rdata <= dem1_reg;
        mcx_pkg::A_STATE: o_rdata <= {28'h000_0000, halt_reg, merr_reg, rev_reg, fwd_reg};
        mcx_pkg::A_IRQ_ST: o_rdata <= 32'(irq_st_reg);
        mcx_pkg::A_IRQ_MSK: o_rdata <= 32'(irq_msk_reg);
        mcx_pkg::A_POS0: o_rdata <= pos0_reg;
        mcx_pkg::A_POS1: o_rdata <= pos1_reg;
        mcx_pkg::A_FERR0: o_rdata <= fe0;
        default: o_rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_fe_read: assert property (i_rd && i_addr == mcx_pkg::A_FERR0 |=> o_rdata == $past(fe0))
    else $error("following error readback wrong");
  chk_fe_trip: assert property (tick && run && fe_over |=> merr_reg ##1 !o_drv_enable)
    else $error("error over limit did not stop drive");
  chk_comm_halt: assert property (tick && wait_reg |=> halt_reg && o_halted)
    else $error("missing driver answer not halted");
  chk_halt_ref: assert property (o_halted |=> o_drv_ref == 32'h0000_0000)
    else $error("reference not zero while halted");
  chk_open_ref: assert property (tick && run && !fe_over && ctrl_reg[3:2] == 2'b10
    |=> o_drv_ref == $past(speed_reg))
    else $error("open-loop reference wrong");
  chk_torque_ref: assert property (tick && run && !fe_over && ctrl_reg[2]
    |=> o_drv_ref == $past(torq_reg) && o_drv_torque)
    else $error("torque reference wrong");
  chk_axis_legal: assert property (atype1_reg inside {8'h00, 8'h02, 8'h03, 8'h0E})
    else $error("illegal axis 1 type");
  chk_enc_count: assert property (enc_up |=> pos1_reg == $past(pos1_reg) + 32'h0000_0001)
    else $error("encoder up count missed");
  chk_enc_bad: assert property (enc_bad |=> pos1_reg == $past(pos1_reg))
    else $error("double transition counted");
  chk_virt_pos: assert property (atype1_reg == 8'h00 ##1 atype1_reg == 8'h00
    |-> pos1_reg == $past(dem1_reg))
    else $error("virtual position not demand");
  chk_lim_bit: assert property (fwd_now |=> fwd_reg)
    else $error("forward limit bit not set");
  chk_out_step: assert property (atype1_reg == mcx_pkg::AT_ENC_OUT &&
    $past(atype1_reg) == mcx_pkg::AT_ENC_OUT && edges_reg != $past(edges_reg)
    |-> step_reg == 8'(mcx_pkg::ENC_STEP_CYC - 1))
    else $error("output edge rate exceeded");
  cov_trip: cover property (tick && run && fe_over);
  cov_comm: cover property (tick && wait_reg);
  cov_z: cover property ($rose(o_enc_z));
endmodule

// ==== testbench/mcx_drv_model.sv ====
// Behavioural servo driver and external quadrature encoder for mcx_top.
// Assumes the driver shares the block clock; the bench steers it by name.
`timescale 1ns/1ps
module mcx_drv_model (
  input wire logic i_clk,
  input wire logic i_strobe,
  output logic o_ack,
  output logic [31:0] o_pos0,
  output logic [31:0] o_pos1,
  output logic o_fwd_lim,
  output logic o_rev_lim,
  output logic o_enc_a,
  output logic o_enc_b
);
  logic [1:0] ph = 2'b00;
  logic mute = 1'b0;
  int lag = 3;
  int cnt = -1;
  initial
  begin
    o_ack = 1'b0;
    o_pos0 = 32'h0000_0100;
    o_pos1 = 32'h0000_0000;
    o_fwd_lim = 1'b0;
    o_rev_lim = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // no answer while muted
  always @(posedge i_clk)
  begin
    if (i_strobe && !mute)
      cnt <= lag;
    else if (cnt >= 0)
      cnt <= cnt - 1;
    o_ack <= (cnt == 0);
  end
  ////////////////////////////////////////////////////////////////////////////
  // A leads counting up
  assign o_enc_a = ph[1] ^ ph[0];
  assign o_enc_b = ph[1];
  task automatic step(input logic [1:0] d);
    @(posedge i_clk);
    ph <= ph + d;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// ==== testbench/motion_axis_encoder_control_bench.sv ====
// Self-checking bench for mcx_top through its register port.
// Assumes servo counts shortened to 50 and 100 cycles.
`timescale 1ns/1ps
module motion_axis_encoder_control_bench;
  logic i_clk, i_resetn, wr, rd, irq, strobe, ack, en, torq, flim, rlim;
  logic ea, eb, oa, ob, oz, halted;
  logic [7:0] addr, gen;
  logic [31:0] wdata, rdata, pos0, pos1, dref, dref1;
  logic [1:0] f;
  int err_count = 0;
  int total_checks = 0;
  int n;
  logic [7:0] ra [6] = '{mcx_pkg::A_CTRL, mcx_pkg::A_AXIS_TYPE_SELECT, mcx_pkg::A_FEMAX,
    mcx_pkg::A_LIMSEL, mcx_pkg::A_IRQ_MSK, 8'h3C};
  logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_030D, 32'h0000_1000,
    32'h0000_1312, 32'h0000_0000, 32'h0000_0000};
  logic [7:0] codes [4] = '{8'h00, 8'h02, 8'h0E, 8'h03};
  mcx_top #(.SHORT_CYC(50), .LONG_CYC(100), .GEN_W(8)) DUT (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .o_drv_strobe(strobe),
    .i_drv_ack(ack), .i_drv_pos0(pos0), .i_drv_pos1(pos1), .o_drv_enable(en),
    .o_drv_torque(torq), .o_drv_ref(dref), .o_drv_ref1(dref1),
    .i_drv_fwd_lim(flim), .i_drv_rev_lim(rlim), .i_gen_in(gen),
    .i_enc_a(ea), .i_enc_b(eb), .o_enc_a(oa), .o_enc_b(ob), .o_enc_z(oz),
    .o_halted(halted));
  mcx_drv_model drv (
    .i_clk(i_clk), .i_strobe(strobe), .o_ack(ack), .o_pos0(pos0),
    .o_pos1(pos1), .o_fwd_lim(flim), .o_rev_lim(rlim), .o_enc_a(ea),
    .o_enc_b(eb));
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic wait_strobe(output int c);
    c = 0;
    do
    begin
      @(posedge i_clk);
      #1 c++;
    end
    while (strobe !== 1'b1 && c < 300);
    if (c >= 300)
    begin
      err_count++;
      $display("[ERR] %0t no driver strobe", $time);
      wrap_up();
    end
  endtask
  task automatic enc_watch(output int e, output logic [1:0] fe);
    logic [1:0] last;
    last = {oa, ob};
    e = 0;
    fe = 2'b00;
    repeat (300)
    begin
      @(posedge i_clk);
      #1;
      if ({oa, ob} !== last)
      begin
        if (e == 0)
          fe = {oa, ob};
        e++;
        last = {oa, ob};
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_resetn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    gen = 8'h00;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd_chk(ra[i], rv[i], 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(mcx_pkg::A_AXIS_TYPE_SELECT, {8'h00, 8'hFF, codes[i], 8'hFF});
      rd_chk(mcx_pkg::A_AXIS_TYPE_SELECT, {16'h0000, codes[i], 8'h0D}, 32'hFFFF_FFFF);
    end
    wr_reg(mcx_pkg::A_AXIS_TYPE_SELECT, 32'h0000_0500);
    rd_chk(mcx_pkg::A_AXIS_TYPE_SELECT, 32'h0000_030D, 32'hFFFF_FFFF);
    repeat (8) drv.step(2'd1);
    rd_chk(mcx_pkg::A_POS1, 32'h0000_0008, 32'hFFFF_FFFF);
    repeat (3) drv.step(2'd3);
    drv.step(2'd2);
    rd_chk(mcx_pkg::A_POS1, 32'h0000_0005, 32'hFFFF_FFFF);
    rd_chk(mcx_pkg::A_IRQ_ST, 32'h0000_0010, 32'h0000_0010);
    wr_reg(mcx_pkg::A_AXIS_TYPE_SELECT, 32'h0000_0000);
    wr_reg(mcx_pkg::A_DEM1, 32'h0000_0077);
    rd_chk(mcx_pkg::A_POS1, 32'h0000_0077, 32'hFFFF_FFFF);
    wr_reg(mcx_pkg::A_DEM1, 32'h0000_0000);
    wr_reg(mcx_pkg::A_DEM0, 32'h0000_0100);
    wr_reg(mcx_pkg::A_GAIN, 32'h0000_0002);
    wr_reg(mcx_pkg::A_SPEED, 32'h0000_1234);
    wr_reg(mcx_pkg::A_TORQ, 32'h0000_0055);
    wr_reg(mcx_pkg::A_CTRL, 32'h0000_0009);
    wait_strobe(n);
    chk(dref, 32'h0000_1234);
    chk({30'd0, en, torq}, 32'h0000_0002);
    wait_strobe(n);
    chk(32'(n), 32'd50);
    wr_reg(mcx_pkg::A_CTRL, 32'h0000_0005);
    wait_strobe(n);
    chk({dref[30:0], torq}, {31'h0000_0055, 1'b1});
    drv.o_pos0 <= 32'h0000_00F0;
    wr_reg(mcx_pkg::A_CTRL, 32'h0000_0001);
    repeat (2) wait_strobe(n);
    chk(dref, 32'h0000_0020);
    rd_chk(mcx_pkg::A_FERR0, 32'h0000_0010, 32'hFFFF_FFFF);
    wr_reg(mcx_pkg::A_AXIS_TYPE_SELECT, 32'h0000_0200);
    drv.o_pos1 <= 32'h0000_0008;
    wr_reg(mcx_pkg::A_DEM1, 32'h0000_0010);
    repeat (2) wait_strobe(n);
    chk(dref1, 32'h0000_0010);
    rd_chk(mcx_pkg::A_POS1, 32'h0000_0008, 32'hFFFF_FFFF);
    wr_reg(mcx_pkg::A_AXIS_TYPE_SELECT, 32'h0000_0000);
    wr_reg(mcx_pkg::A_DEM1, 32'h0000_0000);
    drv.lag = 80;
    wr_reg(mcx_pkg::A_CTRL, 32'h0000_0003);
    repeat (3) wait_strobe(n);
    chk({31'd0, halted}, 32'(n - 100));
    drv.lag = 3;
    drv.o_fwd_lim <= 1'b1;
    repeat (8) @(posedge i_clk);
    rd_chk(mcx_pkg::A_STATE, 32'h0000_0001, 32'h0000_0003);
    drv.o_fwd_lim <= 1'b0;
    wr_reg(mcx_pkg::A_LIMSEL, 32'h0000_1302);
    gen <= 8'h04;
    repeat (8) @(posedge i_clk);
    rd_chk(mcx_pkg::A_STATE, 32'h0000_0001, 32'h0000_0003);
    rd_chk(mcx_pkg::A_IRQ_ST, 32'h0000_0004, 32'h0000_0004);
    gen <= 8'h00;
    wr_reg(mcx_pkg::A_LIMSEL, 32'h0000_1312);
    drv.o_rev_lim <= 1'b1;
    repeat (8) @(posedge i_clk);
    rd_chk(mcx_pkg::A_STATE, 32'h0000_0002, 32'h0000_0003);
    drv.o_rev_lim <= 1'b0;
    drv.o_pos0 <= 32'h0000_0100;
    wait_strobe(n);
    wr_reg(mcx_pkg::A_DEM0, 32'h0000_1100);
    repeat (2) wait_strobe(n);
    rd_chk(mcx_pkg::A_STATE, 32'h0000_0000, 32'h0000_000C);
    wr_reg(mcx_pkg::A_DEM0, 32'h0000_1101);
    wait_strobe(n);
    repeat (3) @(posedge i_clk);
    #1 chk({dref[30:0], en}, 32'h0000_0000);
    rd_chk(mcx_pkg::A_STATE, 32'h0000_0004, 32'h0000_0004);
    wr_reg(mcx_pkg::A_IRQ_MSK, 32'h0000_0001);
    #1 chk({31'd0, irq}, 32'h0000_0001);
    rd_chk(mcx_pkg::A_IRQ_ST, 32'h0000_0001, 32'h0000_0001);
    chk({31'd0, irq}, 32'h0000_0000);
    wr_reg(mcx_pkg::A_DEM0, 32'h0000_0100);
    wr_reg(mcx_pkg::A_CTRL, 32'h0000_0011);
    rd_chk(mcx_pkg::A_STATE, 32'h0000_0000, 32'h0000_000C);
    drv.mute = 1'b1;
    repeat (120) @(posedge i_clk);
    #1 chk({30'd0, en, halted}, 32'h0000_0001);
    rd_chk(mcx_pkg::A_STATE, 32'h0000_0008, 32'h0000_0008);
    rd_chk(mcx_pkg::A_IRQ_ST, 32'h0000_0002, 32'h0000_0002);
    drv.mute = 1'b0;
    wr_reg(mcx_pkg::A_CTRL, 32'h0000_0010);
    wr_reg(mcx_pkg::A_AXIS_TYPE_SELECT, 32'h0000_0E00);
    repeat (2) @(posedge i_clk);
    #1 chk({29'd0, oa, ob, oz}, 32'h0000_0001);
    wr_reg(mcx_pkg::A_DEM1, 32'h0000_0040);
    enc_watch(n, f);
    chk(32'(n), 32'd4);
    chk({30'd0, f}, 32'h0000_0002);
    chk({29'd0, oa, ob, oz}, 32'h0000_0000);
    wr_reg(mcx_pkg::A_DEM1, 32'h0000_0000);
    enc_watch(n, f);
    chk(32'(n), 32'd4);
    chk({30'd0, f}, 32'h0000_0001);
    chk({29'd0, oa, ob, oz}, 32'h0000_0001);
    wrap_up();
  end
endmodule
